// *** hdl/i2c_target_pkg.sv ***
// Shared constants of the sensor I2C target port and its bus master.
// What this block does
// - Current read: read control byte, data, last NACK.
// - Random read: write pointer, repeated start, read.
// - Writes carry pointer byte then data, all ACKed.
// - Writing 0x81 to 0xDA ignores later stops.
// - Writing 0x01 restores stops; stop closes window.
// - Idle lines for timeout period close the window.
// - Timeout period resets to 10.24 ms.
// - Timeout close keeps reads, discards written commands except those to 0xD9 and 0xDA.
// - Master disables stops first, enables them last.
// - No sub-address bits gives address 0x44.
// - Address is 0x44 ORed with option bits 3,1,0.
// - Option bit 6 selects communication during tuning.
// - Option bit 7 disables magnetic sensors on later versions.
// - Programmer leaves bits 5,4 (and early bit 7) alone.
// - Ready line open drain, low during window.
// - Outside window: ACK address, stretch clock until open.
package i2c_target_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [7:0] REG_TIMEOUT = 8'hD9;
  localparam logic [7:0] REG_STOP_CTRL = 8'hDA;
  localparam logic [7:0] STOP_DISABLE_VAL = 8'h81;
  localparam logic [7:0] STOP_ENABLE_VAL = 8'h01;
  localparam logic [7:0] STOP_CTRL_RST = 8'h01;
  localparam int STOP_DIS_BIT = 7;
  localparam logic [6:0] BASE_ADDR = 7'h44;
  localparam int OTP_SUB0 = 0;
  localparam int OTP_SUB1 = 1;
  localparam int OTP_OSC_4MHZ = 2;
  localparam int OTP_SUB3 = 3;
  localparam int OTP_COMMS_TUNE = 6;
  localparam int OTP_HALL_DIS = 7;
  // The period register counts 40 us ticks plus one, so 0xFF gives 10.24 ms.
  localparam int TIMEOUT_TICK_NS = 40000;
  localparam int TICK_CYCLES = (TIMEOUT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TIMEOUT_RST = 8'hFF;
  localparam int BIT_PERIOD_NS = 10000;
  localparam int QTR_CYCLES = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage

// *** hdl/i2c_link_if.sv ***
// Open-drain I2C link with ready line between the sensor target and its master.
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_m_oe;
  logic scl_m_o;
  logic sda_m_oe;
  logic sda_m_o;
  logic scl_t_oe;
  logic scl_t_o;
  logic sda_t_oe;
  logic sda_t_o;
  logic rdy_oe;
  logic rdy_o;
  logic scl;
  logic sda;
  logic rdy_n;
  // Pull-ups: a line is low only while some party enables a low drive.
  assign scl = (~scl_m_oe | scl_m_o) & (~scl_t_oe | scl_t_o);
  assign sda = (~sda_m_oe | sda_m_o) & (~sda_t_oe | sda_t_o);
  assign rdy_n = ~rdy_oe | rdy_o;
  modport target (input scl, input sda, output scl_t_oe, output scl_t_o, output sda_t_oe, output sda_t_o,
                  output rdy_oe, output rdy_o);
  modport master (input scl, input sda, input rdy_n, output scl_m_oe, output scl_m_o, output sda_m_oe,
                  output sda_m_o);
endinterface

// *** hdl/sensor_i2c_target_port.sv ***
// Sensor I2C target end: byte engine, register pointer, window and ready timeout.
`timescale 1ns/1ps
module sensor_i2c_target_port #(
  parameter int TICK_CYCLES = i2c_target_pkg::TICK_CYCLES
)(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  i2c_link_if.target bus,
  input wire logic i_window_req,
  input wire logic [7:0] i_otp_bank0,
  input wire logic [7:0] i_rd_data,
  output logic [7:0] o_rd_addr,
  output logic o_wr_valid,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_window_open,
  output logic o_window_commit,
  output logic o_window_discard,
  output logic o_comms_during_tuning,
  output logic o_osc_4mhz_sel,
  output logic o_hall_disable
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 4095)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_STRETCH, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK}
    state_e;

  // ----------------------------------------------------------------
  // Line synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic need_ptr_q;
  logic nack_q;
  logic [7:0] ptr_q;
  logic sda_oe_q;
  logic scl_oe_q;
  logic [7:0] timeout_q;
  logic [7:0] stop_ctrl_q;
  logic wr_valid_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic win_q;
  logic commit_q;
  logic discard_q;
  logic [11:0] tick_q;
  logic [7:0] period_q;
  logic [7:0] otp_q;
  logic otp_taken_q;

  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire activity = (scl_s ^ scl_prev_q) | (sda_s ^ sda_prev_q);
  wire stop_ignored = stop_ctrl_q[i2c_target_pkg::STOP_DIS_BIT];
  wire close_by_stop = stop_seen & win_q & ~stop_ignored;
  wire tick_done = tick_q == 12'(TICK_CYCLES - 1);
  wire timeout_hit = win_q & tick_done & (period_q == timeout_q);
  wire [6:0] own_addr = i2c_target_pkg::BASE_ADDR | {3'h0, otp_q[i2c_target_pkg::OTP_SUB3], 1'b0,
                        otp_q[i2c_target_pkg::OTP_SUB1], otp_q[i2c_target_pkg::OTP_SUB0]};
  wire [7:0] tx_byte = (ptr_q == i2c_target_pkg::REG_TIMEOUT) ? timeout_q :
                       (ptr_q == i2c_target_pkg::REG_STOP_CTRL) ? stop_ctrl_q : i_rd_data;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      need_ptr_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      timeout_q <= i2c_target_pkg::TIMEOUT_RST;
      stop_ctrl_q <= i2c_target_pkg::STOP_CTRL_RST;
      wr_valid_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end
    else
    begin
      wr_valid_q <= 1'b0;
      if (start_seen)
      begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end
      else if (stop_seen)
      begin
        // An ignored stop still ends the transaction; only the window stays open.
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          ST_IDLE:
          begin
          end
          ST_ADDR:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              if (shift_q[7:1] == own_addr)
              begin
                rw_q <= shift_q[0];
                sda_oe_q <= 1'b1;
                state_q <= ST_ADDR_ACK;
              end
              else
                state_q <= ST_IDLE;
            end
          end
          ST_ADDR_ACK:
          begin
            if (scl_fall)
            begin
              // Data goes out now, before any stretch lets the clock rise.
              shift_q <= tx_byte;
              sda_oe_q <= rw_q & ~tx_byte[7];
              scl_oe_q <= ~win_q;
              state_q <= ST_STRETCH;
            end
          end
          ST_STRETCH:
          begin
            if (win_q)
            begin
              scl_oe_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              if (rw_q)
                state_q <= ST_TX;
              else
              begin
                need_ptr_q <= 1'b1;
                state_q <= ST_RX;
              end
            end
          end
          ST_RX:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              sda_oe_q <= 1'b1;
              state_q <= ST_RX_ACK;
              if (need_ptr_q)
              begin
                ptr_q <= shift_q;
                need_ptr_q <= 1'b0;
              end
              else
              begin
                ptr_q <= ptr_q + 8'h01;
                wr_valid_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                if (ptr_q == i2c_target_pkg::REG_TIMEOUT)
                  timeout_q <= shift_q;
                if (ptr_q == i2c_target_pkg::REG_STOP_CTRL)
                  stop_ctrl_q <= shift_q;
              end
            end
          end
          ST_RX_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q <= ST_RX;
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_q == 4'h7)
              begin
                sda_oe_q <= 1'b0;
                state_q <= ST_TX_ACK;
              end
              else
              begin
                sda_oe_q <= ~shift_q[6];
                shift_q <= {shift_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_TX_ACK:
          begin
            if (scl_rise)
            begin
              nack_q <= sda_s;
              ptr_q <= ptr_q + 8'h01;
            end
            else if (scl_fall)
            begin
              bit_cnt_q <= 4'h0;
              if (nack_q)
                state_q <= ST_IDLE;
              else
              begin
                shift_q <= tx_byte;
                sda_oe_q <= ~tx_byte[7];
                state_q <= ST_TX;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Communication window and ready timeout
  // ----------------------------------------------------------------
  // Writes are streamed out at once; the user side must hold them until commit, since a
  // timed-out window throws them away and only a recognised stop makes them take effect.
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      win_q <= 1'b0;
      commit_q <= 1'b0;
      discard_q <= 1'b0;
    end
    else
    begin
      commit_q <= close_by_stop;
      discard_q <= timeout_hit & ~close_by_stop;
      if (close_by_stop || timeout_hit)
        win_q <= 1'b0;
      else if (i_window_req)
        win_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      tick_q <= 12'h000;
      period_q <= 8'h00;
    end
    else if (!win_q || activity)
    begin
      tick_q <= 12'h000;
      period_q <= 8'h00;
    end
    else if (tick_done)
    begin
      tick_q <= 12'h000;
      period_q <= period_q + 8'h01;
    end
    else
      tick_q <= tick_q + 12'h001;
  end

  // ----------------------------------------------------------------
  // One-time option bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      otp_q <= 8'h00;
      otp_taken_q <= 1'b0;
    end
    else if (!otp_taken_q)
    begin
      otp_q <= i_otp_bank0;
      otp_taken_q <= 1'b1;
    end
  end

  assign o_comms_during_tuning = otp_q[i2c_target_pkg::OTP_COMMS_TUNE];
  assign o_osc_4mhz_sel = otp_q[i2c_target_pkg::OTP_OSC_4MHZ];
  assign o_hall_disable = otp_q[i2c_target_pkg::OTP_HALL_DIS];
  assign o_rd_addr = ptr_q;
  assign o_wr_valid = wr_valid_q;
  assign o_wr_addr = wr_addr_q;
  assign o_wr_data = wr_data_q;
  assign o_window_open = win_q;
  assign o_window_commit = commit_q;
  assign o_window_discard = discard_q;
  assign bus.scl_t_oe = scl_oe_q;
  assign bus.scl_t_o = 1'b0;
  assign bus.sda_t_oe = sda_oe_q;
  assign bus.sda_t_o = 1'b0;
  assign bus.rdy_oe = win_q;
  assign bus.rdy_o = 1'b0;

endmodule

// *** hdl/i2c_master_end.sv ***
// Microcontroller-side I2C master for the sensor target: current, random reads and writes.
`timescale 1ns/1ps
module i2c_master_end #(
  parameter int QTR_CYCLES = i2c_target_pkg::QTR_CYCLES
)(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  i2c_link_if.master bus,
  input wire logic i_req,
  input wire logic i_read,
  input wire logic i_set_ptr,
  input wire logic [6:0] i_target_addr,
  input wire logic [7:0] i_ptr,
  input wire logic [3:0] i_len,
  input wire logic [7:0] i_wdata,
  output logic o_wdata_take,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic o_window_open
);

  if (QTR_CYCLES < 2 || QTR_CYCLES > 255)
  begin : g_bad_qtr
    $error("QTR_CYCLES out of range");
  end

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hstate_e;
  typedef enum logic [2:0] {B_CTRL_W, B_PTR, B_WDATA, B_CTRL_R, B_RDATA} byte_e;

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] rdy_sync_q;
  logic [7:0] qcnt_q;
  hstate_e state_q;
  byte_e kind_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [3:0] left_q;
  logic rd_q;
  logic [6:0] addr_q;
  logic [7:0] ptr_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic take_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic busy_q;
  logic done_q;
  logic nack_q;
  logic win_q;

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      rdy_sync_q <= 2'h3;
      win_q <= 1'b0;
      qcnt_q <= 8'h00;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      rdy_sync_q <= {rdy_sync_q[0], bus.rdy_n};
      win_q <= ~rdy_sync_q[1];
      qcnt_q <= (qcnt_q == 8'(QTR_CYCLES - 1)) ? 8'h00 : qcnt_q + 8'h01;
    end
  end

  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire qtick = qcnt_q == 8'(QTR_CYCLES - 1);
  // The last quarter of each step waits for a released clock to read high, which honours stretching.
  wire step = qtick & ((phase_q != 2'h3) | scl_s);
  wire is_rx = kind_q == B_RDATA;
  wire drive_bit = (bit_q == 4'h8) ? (is_rx & (left_q != 4'h1)) : (~is_rx & ~tx_q[7]);

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= H_IDLE;
      kind_q <= B_CTRL_W;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      left_q <= 4'h0;
      rd_q <= 1'b0;
      addr_q <= 7'h00;
      ptr_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      take_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end
    else
    begin
      take_q <= 1'b0;
      rvalid_q <= 1'b0;
      done_q <= 1'b0;
      if (state_q == H_IDLE)
      begin
        if (i_req)
        begin
          busy_q <= 1'b1;
          nack_q <= 1'b0;
          rd_q <= i_read;
          addr_q <= i_target_addr;
          ptr_q <= i_ptr;
          left_q <= i_len;
          kind_q <= (i_read && !i_set_ptr) ? B_CTRL_R : B_CTRL_W;
          phase_q <= 2'h2;
          state_q <= H_START;
        end
      end
      else if (step)
      begin
        phase_q <= phase_q + 2'h1;
        unique case (state_q)
          H_START:
          begin
            if (phase_q == 2'h0)
              scl_oe_q <= 1'b1;
            else if (phase_q == 2'h1)
              sda_oe_q <= 1'b0;
            else if (phase_q == 2'h2)
              scl_oe_q <= 1'b0;
            else
            begin
              sda_oe_q <= 1'b1;
              bit_q <= 4'h0;
              tx_q <= {addr_q, kind_q == B_CTRL_R};
              state_q <= H_BIT;
            end
          end
          H_STOP:
          begin
            if (phase_q == 2'h0)
              scl_oe_q <= 1'b1;
            else if (phase_q == 2'h1)
              sda_oe_q <= 1'b1;
            else if (phase_q == 2'h2)
              scl_oe_q <= 1'b0;
            else
            begin
              sda_oe_q <= 1'b0;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= H_IDLE;
            end
          end
          H_BIT:
          begin
            if (phase_q == 2'h0)
              scl_oe_q <= 1'b1;
            else if (phase_q == 2'h1)
              sda_oe_q <= drive_bit;
            else if (phase_q == 2'h2)
              scl_oe_q <= 1'b0;
            else if (bit_q != 4'h8)
            begin
              rx_q <= {rx_q[6:0], sda_s};
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
            else
            begin
              bit_q <= 4'h0;
              if (!is_rx && sda_s)
              begin
                nack_q <= 1'b1;
                state_q <= H_STOP;
              end
              else
              begin
                unique case (kind_q)
                  B_CTRL_W:
                  begin
                    kind_q <= B_PTR;
                    tx_q <= ptr_q;
                  end
                  B_PTR:
                  begin
                    if (rd_q)
                    begin
                      kind_q <= B_CTRL_R;
                      state_q <= H_START;
                    end
                    else
                    begin
                      kind_q <= B_WDATA;
                      tx_q <= i_wdata;
                      take_q <= 1'b1;
                    end
                  end
                  B_WDATA:
                  begin
                    left_q <= left_q - 4'h1;
                    if (left_q == 4'h1)
                      state_q <= H_STOP;
                    else
                    begin
                      tx_q <= i_wdata;
                      take_q <= 1'b1;
                    end
                  end
                  B_CTRL_R:
                    kind_q <= B_RDATA;
                  B_RDATA:
                  begin
                    rdata_q <= rx_q;
                    rvalid_q <= 1'b1;
                    left_q <= left_q - 4'h1;
                    if (left_q == 4'h1)
                      state_q <= H_STOP;
                  end
                endcase
              end
            end
          end
          H_IDLE:
          begin
          end
        endcase
      end
    end
  end

  assign o_wdata_take = take_q;
  assign o_rdata = rdata_q;
  assign o_rdata_valid = rvalid_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_nack = nack_q;
  assign o_window_open = win_q;
  assign bus.scl_m_oe = scl_oe_q;
  assign bus.scl_m_o = 1'b0;
  assign bus.sda_m_oe = sda_oe_q;
  assign bus.sda_m_o = 1'b0;

endmodule

// *** tb/sensor_link_monitor.sv ***
// Checker of the open-drain link between the sensor target and its master.
`timescale 1ns/1ps
module sensor_link_monitor #(
  parameter int TICK_CYCLES = 4
)(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic rdy_n,
  input wire logic scl_t_oe,
  input wire logic sda_t_oe,
  input wire logic rdy_oe
);
  // ----
  // Quiet and stop counters
  // ----
  // The quiet count restarts while the window is shut, since the timeout only runs in a window.
  localparam int IDLE_MAX = 256 * TICK_CYCLES + 6;
  logic sda_p_q;
  logic scl_p_q;
  logic [15:0] idle_q;
  logic [15:0] stop_q;
  wire moved = (sda != sda_p_q) || (scl != scl_p_q) || !rdy_oe;
  wire stop_seen = scl && scl_p_q && sda && !sda_p_q;
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
      idle_q <= 16'h0000;
      stop_q <= 16'hFFFF;
    end
    else
    begin
      sda_p_q <= sda;
      scl_p_q <= scl;
      idle_q <= moved ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hFFFF};
      stop_q <= stop_seen ? 16'h0000 : stop_q + {15'h0000, stop_q != 16'hFFFF};
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_ready_drive_low: assert property (rdy_oe && !scl |=> rdy_oe)
    else $error("window closed with clock low");
  a_ack_set_low: assert property ($rose(sda_t_oe) |-> !scl)
    else $error("target data changed with clock high");
  a_ack_stands_high: assert property (sda_t_oe && scl |=> sda_t_oe || !scl)
    else $error("target data released with clock high");
  a_stretch_closed: assert property ($rose(scl_t_oe) |-> !rdy_oe)
    else $error("stretch began inside a window");
  a_stretch_released: assert property ($fell(scl_t_oe) |-> rdy_oe)
    else $error("stretch ended with window shut");
  a_no_stretch_open: assert property (rdy_oe [*3] |-> !scl_t_oe)
    else $error("clock held low inside a window");
  a_quiet_bound: assert property (rdy_oe |-> idle_q <= IDLE_MAX)
    else $error("quiet window outlived the longest timeout");
  a_close_has_cause: assert property ($fell(rdy_oe) |-> stop_q < 8 || idle_q + 4 >= TICK_CYCLES)
    else $error("window closed without stop or quiet");
endmodule

// *** tb/tb_top.sv ***
// Bench joining the sensor target and its master over the link.
`timescale 1ns/1ps
module tb_top;
  // ----
  // Signals and instances
  // ----
  localparam int TICK = 8;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic win_req = 1'b0;
  logic [7:0] otp = 8'h00;
  logic [7:0] rd_data = 8'h00;
  logic req = 1'b0;
  logic rd = 1'b0;
  logic sp = 1'b0;
  logic [6:0] taddr = 7'h00;
  logic [7:0] ptr = 8'h00;
  logic [3:0] len = 4'h1;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rd_addr, wr_addr, wr_data, m_rdata, mptr, r_d9, r_da;
  logic wr_valid, t_open, commit, discard, tune, osc4, hall, take, m_rv, m_busy, m_done, m_nack, m_open;
  logic [6:0] dev;
  logic [7:0] wbuf [16];
  logic [7:0] exp_rd [$];
  logic [15:0] exp_wr [$];
  int fail_count = 0;
  int comparisons = 0;
  int ncommit = 0;
  int ndisc = 0;
  int ec = 0;
  int widx = 0;
  int i;
  int seed = 32'h4651FA9A;
  always #(i2c_target_pkg::CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;
  i2c_link_if link ();
  sensor_i2c_target_port #(.TICK_CYCLES(TICK)) sensor_i2c_target_port_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .bus(link.target), .i_window_req(win_req), .i_otp_bank0(otp), .i_rd_data(rd_data), .o_rd_addr(rd_addr),
    .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_window_open(t_open),
    .o_window_commit(commit), .o_window_discard(discard), .o_comms_during_tuning(tune),
    .o_osc_4mhz_sel(osc4), .o_hall_disable(hall));
  i2c_master_end #(.QTR_CYCLES(4)) i2c_master_end_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .bus(link.master),
    .i_req(req), .i_read(rd), .i_set_ptr(sp), .i_target_addr(taddr), .i_ptr(ptr), .i_len(len), .i_wdata(wdata),
    .o_wdata_take(take), .o_rdata(m_rdata), .o_rdata_valid(m_rv), .o_busy(m_busy), .o_done(m_done),
    .o_nack(m_nack), .o_window_open(m_open));
  sensor_link_monitor #(.TICK_CYCLES(TICK)) sensor_link_monitor_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .scl(link.scl), .sda(link.sda), .rdy_n(link.rdy_n), .scl_t_oe(link.scl_t_oe), .sda_t_oe(link.sda_t_oe),
    .rdy_oe(link.rdy_oe));
  // ----
  // Tasks and models
  // ----
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok)
    begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    if (a == i2c_target_pkg::REG_TIMEOUT) return r_d9;
    if (a == i2c_target_pkg::REG_STOP_CTRL) return r_da;
    return {a[3:0], a[7:4]} ^ 8'hA5;
  endfunction
  always @(posedge i_sys_clk)
  begin
    rd_data <= {rd_addr[3:0], rd_addr[7:4]} ^ 8'hA5;
    if (take)
    begin
      widx <= widx + 1;
      wdata <= wbuf[(widx + 1) % 16];
    end
    if (wr_valid) chk(exp_wr.size() != 0 && exp_wr.pop_front() === {wr_addr, wr_data}, "write");
    if (m_rv) chk(exp_rd.size() != 0 && exp_rd.pop_front() === m_rdata, "read");
    if (commit) ncommit++;
    if (discard) ndisc++;
  end
  task automatic do_reset(input logic [7:0] o);
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    otp <= o;
    cyc(3);
    i_reset <= 1'b0;
    cyc(3);
    dev = i2c_target_pkg::BASE_ADDR | {o[3], 1'b0, o[1:0]};
    r_d9 = i2c_target_pkg::TIMEOUT_RST;
    r_da = i2c_target_pkg::STOP_CTRL_RST;
    mptr = 8'h00;
    chk({tune, osc4, hall} === {o[6], o[2], o[7]}, "options");
  endtask
  task automatic open_win();
    @(posedge i_sys_clk);
    win_req <= 1'b1;
    @(posedge i_sys_clk);
    win_req <= 1'b0;
    cyc(6);
    chk(link.rdy_n === 1'b0 && t_open === 1'b1 && m_open === 1'b1, "ready low");
  endtask
  task automatic xact(input bit r, input bit s, input logic [6:0] a, input logic [7:0] p, input logic [3:0] n,
                      input bit hold);
    int k;
    if (a == dev)
    begin
      if (!r || s) mptr = p;
      for (k = 0; k < n; k++)
      begin
        if (r) exp_rd.push_back(exp_byte(mptr));
        else exp_wr.push_back({mptr, wbuf[k]});
        if (!r && mptr == i2c_target_pkg::REG_TIMEOUT) r_d9 = wbuf[k];
        if (!r && mptr == i2c_target_pkg::REG_STOP_CTRL) r_da = wbuf[k];
        mptr++;
      end
      if (!r_da[i2c_target_pkg::STOP_DIS_BIT]) ec++;
    end
    @(posedge i_sys_clk);
    {req, rd, sp, taddr, ptr, len} <= {1'b1, r, s, a, p, n};
    widx <= 0;
    wdata <= wbuf[0];
    @(posedge i_sys_clk);
    req <= 1'b0;
    if (hold)
    begin
      cyc(400);
      chk(link.scl_t_oe === 1'b1 && link.scl === 1'b0 && m_busy === 1'b1, "stretch");
      open_win();
    end
    for (k = 0; k < 3000 && m_done !== 1'b1; k++) @(posedge i_sys_clk);
    chk(m_done === 1'b1 && m_nack === (a != dev), "address ack");
    cyc(8);
    chk(ncommit === ec && exp_wr.size() == 0 && exp_rd.size() == 0, "commit count");
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] v);
    wbuf[0] = v;
    xact(1'b0, 1'b1, dev, a, 4'h1, 1'b0);
  endtask
  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (60000) @(posedge i_sys_clk);
    fail_count++;
    $display("BAD %0t watchdog", $time);
    end_of_test();
  end
  initial
  begin
    foreach (wbuf[j]) wbuf[j] = 8'($random(seed));
    do_reset(8'h00);
    chk(dev === 7'h44, "base address");
    open_win();
    cyc(256 * TICK - 20);
    chk(link.rdy_n === 1'b0, "early close");
    cyc(40);
    chk(link.rdy_n === 1'b1 && ndisc === 1, "timeout close");
    xact(1'b1, 1'b0, dev, 8'h00, 4'h3, 1'b1);
    chk(link.rdy_n === 1'b1, "ready released");
    open_win();
    xact(1'b0, 1'b1, dev, 8'hFE, 4'h3, 1'b0);
    open_win();
    xact(1'b1, 1'b1, dev, 8'hFE, 4'h3, 1'b0);
    open_win();
    xact(1'b1, 1'b0, dev, 8'h00, 4'h2, 1'b0);
    for (i = 0; i < 6; i++)
    begin
      foreach (wbuf[j]) wbuf[j] = 8'($random(seed));
      open_win();
      xact(i % 3 != 0, i % 3 != 2, dev, 8'($random(seed)) & 8'h7F, 4'(1 + ($random(seed) & 3)), 1'b0);
    end
    open_win();
    wr1(i2c_target_pkg::REG_STOP_CTRL, i2c_target_pkg::STOP_DISABLE_VAL);
    chk(link.rdy_n === 1'b0, "stop ignored");
    xact(1'b1, 1'b1, dev, i2c_target_pkg::REG_STOP_CTRL, 4'h1, 1'b0);
    xact(1'b0, 1'b1, dev, 8'($random(seed)) & 8'h7F, 4'h2, 1'b0);
    wr1(i2c_target_pkg::REG_STOP_CTRL, i2c_target_pkg::STOP_ENABLE_VAL);
    chk(link.rdy_n === 1'b1, "stop restored");
    open_win();
    wr1(i2c_target_pkg::REG_STOP_CTRL, i2c_target_pkg::STOP_DISABLE_VAL);
    wr1(i2c_target_pkg::REG_TIMEOUT, 8'h02);
    xact(1'b1, 1'b1, dev, i2c_target_pkg::REG_TIMEOUT, 4'h2, 1'b0);
    cyc(3 * TICK + 16);
    chk(link.rdy_n === 1'b1 && ndisc === 2 && ncommit === ec, "discard close");
    do_reset(8'($random(seed)) & 8'hCF);
    xact(1'b1, 1'b0, dev ^ 7'h08, 8'h00, 4'h1, 1'b0);
    xact(1'b1, 1'b0, dev ^ 7'h10, 8'h00, 4'h1, 1'b0);
    open_win();
    xact(1'b1, 1'b1, dev, i2c_target_pkg::REG_TIMEOUT, 4'h2, 1'b0);
    end_of_test();
  end
endmodule
